// ---- verilog/ext_bus_wait_status_outputs.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// - With two or more wait states, strobe goes low at first wait state.
// - Strobe returns high at the start of the last software wait state.
// - Strobe looped to ready adds exactly one external wait state.
// - Strobe pin floats while the float input is low.
// - Fetch indicator low exactly while an instruction address is out.
// - Fetch indicator floats while the float input is low.
// - Machine clock output toggles every core clock; machine cycles bounded by rising edges.
// - Machine clock output floats while the float input is low.
// - Ready is checked only with two or more waits, after they finish.
// - Ready low extends access one cycle and is resampled until high.
module ext_bus_wait_status_outputs
    import ext_bus_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic accessStart,
    input wire logic accessIsFetch,
    input wire logic [2:0] swWaits,
    input wire logic ready,
    input wire logic outFloatN,
    output logic accessDone,
    output logic busy,
    output logic machine_clock_output,
    output logic machine_clock_output_oe_n,
    output logic wait_complete_strobe,
    output logic wait_complete_strobe_oe_n,
    output logic instr_fetch_indicator_n,
    output logic instr_fetch_indicator_n_oe_n
);
    ext_bus_status_if bus ();
    access_e state;
    access_e next_state;
    logic [WAIT_CNT_W-1:0] waitLeft;
    logic readyMeta;
    logic readySync;
    logic phaseLow;
    logic cycleEnd;
    logic longWaits;

    // Decoded events, each valid only on a machine-cycle end
    logic takeReq;
    logic lastSwWait;
    logic countWait;
    logic strobeRelease;
    logic readyOk;
    logic lastEnd;

    ext_bus_float_pads pads (
        .clk(clk),
        .rst_n(rst_n),
        .outFloatN(outFloatN),
        .bus(bus.pad)
    );

    assign machine_clock_output = bus.mclk;
    assign wait_complete_strobe = bus.strobe;
    assign instr_fetch_indicator_n = bus.fetchN;
    assign machine_clock_output_oe_n = bus.mclkOeN;
    assign wait_complete_strobe_oe_n = bus.strobeOeN;
    assign instr_fetch_indicator_n_oe_n = bus.fetchOeN;

    // Ready comes from the board, so synchronise it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readyMeta <= 1'h1;
            readySync <= 1'h1;
        end else begin
            readyMeta <= ready;
            readySync <= readyMeta;
        end
    end

    // Machine cycle: two core clocks, rising edge opens each cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseLow <= 1'h0;
            bus.mclk <= MCLK_RESET;
        end else begin
            phaseLow <= !phaseLow;
            bus.mclk <= phaseLow;
        end
    end

    // Every decision is taken on the edge that closes a machine cycle
    assign cycleEnd = phaseLow;
    assign longWaits = swWaits >= MIN_SW_WAITS;
    assign busy = state != ST_IDLE;

    // Shared conditions keep state, counter and strobe in step
    assign takeReq = (state == ST_IDLE) && accessStart && cycleEnd;
    assign lastSwWait = (state == ST_SWWAIT) && cycleEnd && (waitLeft == 3'h1);
    assign countWait = (state == ST_SWWAIT) && cycleEnd && (waitLeft != 3'h0);
    assign strobeRelease = (state == ST_SWWAIT) && cycleEnd && (waitLeft == 3'h2);
    assign readyOk = (state == ST_READY) && cycleEnd && readySync;
    assign lastEnd = (state == ST_LAST) && cycleEnd;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (takeReq) begin
                    if (swWaits == 3'h0) begin
                        next_state = ST_LAST;
                    end else begin
                        next_state = ST_SWWAIT;
                    end
                end
            end

            ST_SWWAIT: begin
                if (lastSwWait) begin
                    // Short wait counts never look at ready
                    if (longWaits) begin
                        next_state = ST_READY;
                    end else begin
                        next_state = ST_LAST;
                    end
                end
            end

            ST_READY: begin
                // At least one external wait; ready low adds whole machine cycles
                if (readyOk) begin
                    next_state = ST_LAST;
                end
            end

            ST_LAST: begin
                if (lastEnd) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Pulse is combinational so a new request can follow on the next cycle end
    assign accessDone = lastEnd;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Remaining software wait states, counted per machine cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitLeft <= '0;
        end else if (takeReq) begin
            waitLeft <= swWaits;
        end else if (countWait) begin
            // Guarded at zero so a stray cycle cannot wrap the count
            waitLeft <= waitLeft - 3'h1;
        end
    end

    // Strobe low from first wait state until the last one starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.strobe <= STROBE_IDLE;
        end else if (!longWaits) begin
            bus.strobe <= STROBE_IDLE;
        end else if (takeReq) begin
            bus.strobe <= 1'h0;
        end else if (strobeRelease) begin
            // Released one machine cycle before waits end, so a looped ready is already
            // high at the synchroniser output when the first ready check is made
            bus.strobe <= STROBE_IDLE;
        end
    end

    // Fetch flag tracks the address phase of an instruction access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.fetchN <= FETCH_IDLE_N;
        end else if (takeReq) begin
            bus.fetchN <= !accessIsFetch;
        end else if (accessDone) begin
            bus.fetchN <= FETCH_IDLE_N;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/ext_bus_status_pkg.sv ----
package ext_bus_status_pkg;
    // Software wait states at or above which the strobe and ready check apply
    localparam logic [2:0] MIN_SW_WAITS = 3'h2;
    localparam int WAIT_CNT_W = 3;
    // Machine cycle is two core clocks: high phase then low phase
    localparam logic MCLK_RESET = 1'h1;
    localparam logic STROBE_IDLE = 1'h1;
    localparam logic FETCH_IDLE_N = 1'h1;
    localparam logic OE_OFF_N = 1'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SWWAIT = 2'b01,
        ST_READY = 2'b10,
        ST_LAST = 2'b11
    } access_e;
endpackage

// ---- verilog/ext_bus_status_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ext_bus_status_if;
    logic floatReq;
    logic mclk;
    logic strobe;
    logic fetchN;
    logic mclkOeN;
    logic strobeOeN;
    logic fetchOeN;
    modport core (output mclk, output strobe, output fetchN, input floatReq);
    modport pad (input mclk, input strobe, input fetchN, output floatReq,
        output mclkOeN, output strobeOeN, output fetchOeN);
endinterface
`default_nettype wire

// ---- verilog/ext_bus_float_pads.sv ----
`timescale 1ns/10ps
`default_nettype none
module ext_bus_float_pads
    import ext_bus_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic outFloatN,
    ext_bus_status_if.pad bus
);
    logic floatMeta;
    logic floatSync;

    // Float input is a pin: two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            floatMeta <= 1'h1;
            floatSync <= 1'h1;
        end else begin
            floatMeta <= outFloatN;
            floatSync <= floatMeta;
        end
    end

    assign bus.floatReq = !floatSync;

    // Enables are registered so pins float cleanly on a clock edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.mclkOeN <= OE_OFF_N;
            bus.strobeOeN <= OE_OFF_N;
            bus.fetchOeN <= OE_OFF_N;
        end else begin
            bus.mclkOeN <= !floatSync;
            bus.strobeOeN <= !floatSync;
            bus.fetchOeN <= !floatSync;
        end
    end
endmodule
`default_nettype wire

// ---- dv/ext_bus_status_chk_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module ext_bus_status_chk
    import ext_bus_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] swWaits,
    input wire logic ready,
    input wire logic outFloatN,
    input wire logic accessDone,
    input wire logic busy,
    input wire logic machine_clock_output,
    input wire logic machine_clock_output_oe_n,
    input wire logic wait_complete_strobe,
    input wire logic wait_complete_strobe_oe_n,
    input wire logic instr_fetch_indicator_n,
    input wire logic instr_fetch_indicator_n_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic slow;
    assign slow = swWaits >= MIN_SW_WAITS;
    clk_rise_a: assert property (!machine_clock_output |=> machine_clock_output)
        else $error("clock out stuck low");
    clk_float_a: assert property (!outFloatN [*4] |-> machine_clock_output_oe_n)
        else $error("clock out driven");
    strobe_float_a: assert property (!outFloatN [*4] |-> wait_complete_strobe_oe_n)
        else $error("strobe driven");
    fetch_float_a: assert property (!outFloatN [*4] |-> instr_fetch_indicator_n_oe_n)
        else $error("fetch driven");
    fetch_busy_a: assert property (!instr_fetch_indicator_n |-> busy)
        else $error("fetch low while idle");
    strobe_first_a: assert property ($rose(busy) && slow |-> !wait_complete_strobe)
        else $error("strobe late");
    short_wait_a: assert property (!slow |-> wait_complete_strobe)
        else $error("strobe low");
    ready_hold_a: assert property ((slow && !ready) [*5] |-> !accessDone)
        else $error("done while not ready");
    cover property (accessDone && slow);
    cover property ($rose(busy) && !slow);
    cover property (!outFloatN [*4]);
endmodule
bind ext_bus_wait_status_outputs ext_bus_status_chk ext_bus_status_chk_inst (.*);
`default_nettype wire

// ---- dv/ext_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
    input wire logic clk,
    input wire logic strobe,
    input wire logic loopBack,
    input wire logic [3:0] stall,
    output logic ready
);
    // Starts saturated so an idle device is ready
    logic [3:0] held = 4'hF;
    always_ff @(posedge clk) begin
        held <= !strobe ? 4'h0 : (held == 4'hF ? held : held + 4'h1);
    end
    assign ready = loopBack ? strobe : (held >= stall);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ext_bus_status_pkg::*;
    logic clk = 0, rst_n = 0, start = 0, fetch = 0, floatN = 1, loopBack = 0;
    logic ready, done, busy, mclk, strobe, fetchN;
    logic [2:0] waits = 0, oeN;
    logic [3:0] stall = 0;
    int mismatches = 0, n_tests = 0, ticks = 0;
    ext_bus_wait_status_outputs ext_bus_wait_status_outputs_inst (.clk(clk), .rst_n(rst_n),
        .accessStart(start), .accessIsFetch(fetch), .swWaits(waits), .ready(ready), .outFloatN(floatN),
        .accessDone(done), .busy(busy), .machine_clock_output(mclk), .machine_clock_output_oe_n(oeN[0]),
        .wait_complete_strobe(strobe), .wait_complete_strobe_oe_n(oeN[1]),
        .instr_fetch_indicator_n(fetchN), .instr_fetch_indicator_n_oe_n(oeN[2]));
    ext_mem_model ext_mem_model_inst (.clk(clk), .strobe(strobe), .loopBack(loopBack), .stall(stall),
        .ready(ready));
    initial forever #5 clk = ~clk;
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        ticks++;
        if (ticks == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    // Length counted from the edge that takes the request to the edge ending it
    task automatic access(input logic f, input logic [2:0] w, input logic lb, input logic [3:0] st,
        output int n);
        fetch = f;
        waits = w;
        loopBack = lb;
        stall = st;
        start = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 9) begin
            tick();
            n++;
        end
        start = 1'b0;
        chk(fetchN, !f);
        chk(strobe, w < MIN_SW_WAITS);
        n = 1;
        while (done !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(strobe, 1'b1);
        tick();
        chk(fetchN, 1'b1);
    endtask
    task automatic t_float();
        logic m;
        m = mclk;
        tick();
        chk(mclk, !m);
        floatN = 1'b0;
        repeat (4) tick();
        chk(oeN, 8'h07);
        floatN = 1'b1;
        repeat (4) tick();
        chk(oeN, 8'h00);
    endtask
    task automatic t_prompt();
        int n;
        for (int w = 0; w < 4; w++) begin
            access(w[0], w[2:0], 1'b0, 4'h0, n);
            // Long waits add the ready-sampling machine cycle
            chk(n, 2 * (w + 1) + ((w >= MIN_SW_WAITS) ? 2 : 0));
        end
    endtask
    task automatic t_loop();
        int n;
        access(1'b0, 3'h2, 1'b1, 4'h0, n);
        chk(n, 8'h08);
        access(1'b1, 3'h3, 1'b1, 4'h0, n);
        chk(n, 8'h0A);
    endtask
    task automatic t_stall();
        int n;
        access(1'b1, 3'h2, 1'b0, 4'h6, n);
        chk(n > 8, 1'b1);
        chk(n, 8'h0E);
    endtask
    initial begin
        repeat (6) tick();
        rst_n = 1'b1;
        repeat (4) tick();
        t_float();
        t_prompt();
        t_loop();
        t_stall();
        stop_test();
    end
endmodule
`default_nettype wire
